// *** rtl/osf_top.sv ***
// Output status flag logic: forms selectable status flags from drive quantities.
// Assumes quantities and run come from logic on CLK; lifetime and done from pins.
// Overview of operation
// - Code 21: zero-speed flag high while frequency below zero-speed threshold
// - Zero-speed flag low whenever frequency exceeds threshold
// - Code 22: high when commanded/actual speed difference exceeds limit
// - Code 23: high once positioning completed, low otherwise
// - Code 24: high while running frequency at or above second set frequency
// - Code 25: high while running frequency equals second set frequency
// - Code 26: high while output current exceeds second overload threshold
// - Code 27: high while analog voltage input below its loss level
// - Code 28: high while analog current input below its loss level
// - Code 31: set when running and process variable below low limit
// - PID flag clears above high limit or on run-to-stop; else holds
// - Code 32: high when configurable communications watchdog times out
// - Codes 33-35: flag equals its Boolean operation result
// - Code 39: high once capacitor lifetime expired
// - Code 40: high once fan lifetime expired
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "osf_defines.svh"

module osf_top
  import osf_pkg::*;
#(
  parameter int W    = 16,
  parameter int NOUT = 2
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              NRST,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Drive quantities from the control core
  input  wire logic              RUN,
  input  wire logic [W-1:0]      OUT_FREQ,
  input  wire logic [W-1:0]      SPEED_CMD,
  input  wire logic [W-1:0]      SPEED_ACT,
  input  wire logic [W-1:0]      OUT_CURR,
  input  wire logic [W-1:0]      AIN_VOLT,
  input  wire logic [W-1:0]      AIN_CURR,
  input  wire logic [W-1:0]      PID_PV,
  input  wire logic [2:0]        BOOL_RESULT,
  // Pins from outside the clock domain
  input  wire logic              POS_DONE,
  input  wire logic              CAP_EXPIRED,
  input  wire logic              FAN_EXPIRED,
  // Terminals and interrupt
  output logic      [NOUT-1:0]   TERMINAL,
  output logic                   IRQ
);

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0]            sel_q;
  logic [W-1:0]           thr_zs_q, thr_dev_q, freq2_q, thr_ol2_q;
  logic [W-1:0]           loss_v_q, loss_i_q, pid_lo_q, pid_hi_q;
  logic [31:0]            wdog_q, wd_cnt_q, wd_pre_q;
  logic [`OSF_NFLAG-1:0]  flag_q, flag_d, stat_q, mask_q, flag_dly_q;
  logic [2:0]             p1_q, p2_q, p3_q, pin_q;
  logic                   run_dly_q, kick;
  osf_pid_t               pid_q;
  logic                   wr;
  logic [W-1:0]           dev;

  assign wr = PSEL && PENABLE && PWRITE;
  // Configuration writes; the bus answers with no wait state
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sel_q     <= `OSF_RST_SEL;
      thr_zs_q  <= `OSF_RST_THR;
      thr_dev_q <= `OSF_RST_THR;
      freq2_q   <= `OSF_RST_THR;
      thr_ol2_q <= `OSF_RST_THR;
      loss_v_q  <= `OSF_RST_THR;
      loss_i_q  <= `OSF_RST_THR;
      pid_lo_q  <= `OSF_RST_THR;
      pid_hi_q  <= `OSF_RST_THR;
      wdog_q    <= `OSF_RST_WDOG;
      mask_q    <= '0;
    end else if (wr) begin
      if (PADDR == `OSF_OFF_SEL0) begin
        sel_q[15:0] <= PWDATA[15:0];
      end else if (PADDR == `OSF_OFF_SEL1) begin
        sel_q[31:16] <= PWDATA[15:0];
      end else if (PADDR == `OSF_OFF_THR_ZS) begin
        thr_zs_q <= PWDATA[W-1:0];
      end else if (PADDR == `OSF_OFF_THR_DEV) begin
        thr_dev_q <= PWDATA[W-1:0];
      end else if (PADDR == `OSF_OFF_FREQ2) begin
        freq2_q <= PWDATA[W-1:0];
      end else if (PADDR == `OSF_OFF_THR_OL2) begin
        thr_ol2_q <= PWDATA[W-1:0];
      end else if (PADDR == `OSF_OFF_LOSS_V) begin
        loss_v_q <= PWDATA[W-1:0];
      end else if (PADDR == `OSF_OFF_LOSS_I) begin
        loss_i_q <= PWDATA[W-1:0];
      end else if (PADDR == `OSF_OFF_PID_LO) begin
        pid_lo_q <= PWDATA[W-1:0];
      end else if (PADDR == `OSF_OFF_PID_HI) begin
        pid_hi_q <= PWDATA[W-1:0];
      end else if (PADDR == `OSF_OFF_WDOG) begin
        wdog_q <= PWDATA;
      end else if (PADDR == `OSF_OFF_IRQ_MASK) begin
        mask_q <= PWDATA[`OSF_NFLAG-1:0];
      end
    end
  end

  assign kick = wr && (PADDR == `OSF_OFF_KICK);

  // Read mux; unmapped addresses above OSF_OFF_PID_HI read zero and flag an error
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PRDATA  <= '0;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
      if (PSEL && !PENABLE) begin
        if (PADDR == `OSF_OFF_SEL0) begin
          PRDATA <= {16'h0000, sel_q[15:0]};
        end else if (PADDR == `OSF_OFF_SEL1) begin
          PRDATA <= {16'h0000, sel_q[31:16]};
        end else if (PADDR == `OSF_OFF_FLAGS) begin
          PRDATA <= 32'(flag_q);
        end else if (PADDR == `OSF_OFF_IRQ_STAT) begin
          PRDATA <= 32'(stat_q);
        end else if (PADDR == `OSF_OFF_IRQ_MASK) begin
          PRDATA <= 32'(mask_q);
        end else if (PADDR == `OSF_OFF_WDOG) begin
          PRDATA <= wdog_q;
        end else if (PADDR[11:6] == 6'h00 && PADDR <= `OSF_OFF_PID_HI) begin
          PRDATA <= '0;
        end else if (PADDR != `OSF_OFF_KICK) begin
          PSLVERR <= 1'b1;
        end
      end
    end
  end

  // Pin synchronisers: a change counts once the second and third stage agree
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      p1_q  <= '0;
      p2_q  <= '0;
      p3_q  <= '0;
      pin_q <= '0;
    end else begin
      p1_q <= {FAN_EXPIRED, CAP_EXPIRED, POS_DONE};
      p2_q <= p1_q;
      p3_q <= p2_q;
      for (int i = 0; i < 3; i++) begin
        if (p2_q[i] == p3_q[i]) begin
          pin_q[i] <= p3_q[i];
        end
      end
    end
  end

  // Watchdog: millisecond prescaler, period in ms; zero disables it
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wd_pre_q <= '0;
      wd_cnt_q <= '0;
    end else if (kick || wdog_q == 32'h0000_0000) begin
      wd_pre_q <= '0;
      wd_cnt_q <= '0;
    end else if (wd_cnt_q < wdog_q) begin
      if (wd_pre_q == `OSF_WDOG_UNIT - 32'h0000_0001) begin
        wd_pre_q <= '0;
        wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
      end else begin
        wd_pre_q <= wd_pre_q + 32'h0000_0001;
      end
    end
  end

  // PID second stage: set below low limit while running, clear above high or on stop
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pid_q     <= PID_OFF;
      run_dly_q <= 1'b0;
    end else begin
      run_dly_q <= RUN;
      case (pid_q)
        PID_OFF: begin
          if (RUN && PID_PV < pid_lo_q) begin
            pid_q <= PID_ON;
          end
        end
        default: begin
          if (PID_PV > pid_hi_q || (run_dly_q && !RUN)) begin
            pid_q <= PID_OFF;
          end
        end
      endcase
    end
  end

  // Flag comparators
  assign dev = (SPEED_CMD > SPEED_ACT) ? SPEED_CMD - SPEED_ACT : SPEED_ACT - SPEED_CMD;
  always_comb begin
    flag_d                = '0;
    flag_d[`OSF_B_ZS]  = OUT_FREQ < thr_zs_q;
    flag_d[`OSF_B_DSE] = dev > thr_dev_q;
    flag_d[`OSF_B_POK] = pin_q[0];
    flag_d[`OSF_B_OFA] = RUN && OUT_FREQ >= freq2_q;
    flag_d[`OSF_B_SFA] = RUN && OUT_FREQ == freq2_q;
    flag_d[`OSF_B_OL2] = OUT_CURR > thr_ol2_q;
    flag_d[`OSF_B_VLS] = AIN_VOLT < loss_v_q;
    flag_d[`OSF_B_ILS] = AIN_CURR < loss_i_q;
    flag_d[`OSF_B_PID] = pid_q == PID_ON;
    flag_d[`OSF_B_NET] = wdog_q != 32'h0000_0000 && wd_cnt_q >= wdog_q;
    flag_d[`OSF_B_LGC:`OSF_B_LGA] = BOOL_RESULT;
    flag_d[`OSF_B_CAP] = pin_q[1];
    flag_d[`OSF_B_FAN] = pin_q[2];
  end

  // Flag register and sticky status; a rising flag wins over a clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      flag_q     <= '0;
      flag_dly_q <= '0;
      stat_q     <= '0;
      IRQ        <= 1'b0;
    end else begin
      flag_q     <= flag_d;
      flag_dly_q <= flag_q;
      if (wr && PADDR == `OSF_OFF_IRQ_STAT) begin
        stat_q <= (stat_q & ~PWDATA[`OSF_NFLAG-1:0]) | (flag_q & ~flag_dly_q);
      end else begin
        stat_q <= stat_q | (flag_q & ~flag_dly_q);
      end
      IRQ <= |(stat_q & mask_q);
    end
  end

  // Terminal selection, one per output from the registered flags
  genvar g;
  generate
    for (g = 0; g < NOUT; g++) begin : g_term
      logic [5:0] code;
      assign code = sel_q[g*16 +: 6];
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          TERMINAL[g] <= 1'b0;
        end else begin
          case (code)
            `OSF_CODE_ZS:  TERMINAL[g] <= flag_q[`OSF_B_ZS];
            `OSF_CODE_DSE: TERMINAL[g] <= flag_q[`OSF_B_DSE];
            `OSF_CODE_POK: TERMINAL[g] <= flag_q[`OSF_B_POK];
            `OSF_CODE_OFA: TERMINAL[g] <= flag_q[`OSF_B_OFA];
            `OSF_CODE_SFA: TERMINAL[g] <= flag_q[`OSF_B_SFA];
            `OSF_CODE_OL2: TERMINAL[g] <= flag_q[`OSF_B_OL2];
            `OSF_CODE_VLS: TERMINAL[g] <= flag_q[`OSF_B_VLS];
            `OSF_CODE_ILS: TERMINAL[g] <= flag_q[`OSF_B_ILS];
            `OSF_CODE_PID: TERMINAL[g] <= flag_q[`OSF_B_PID];
            `OSF_CODE_NET: TERMINAL[g] <= flag_q[`OSF_B_NET];
            `OSF_CODE_LGA: TERMINAL[g] <= flag_q[`OSF_B_LGA];
            `OSF_CODE_LGB: TERMINAL[g] <= flag_q[`OSF_B_LGB];
            `OSF_CODE_LGC: TERMINAL[g] <= flag_q[`OSF_B_LGC];
            `OSF_CODE_CAP: TERMINAL[g] <= flag_q[`OSF_B_CAP];
            `OSF_CODE_FAN: TERMINAL[g] <= flag_q[`OSF_B_FAN];
            default:       TERMINAL[g] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // ****************************************
  // Assertions
  // ****************************************
  a_zero_speed: assert property (@(posedge CLK) disable iff (!NRST)
    (OUT_FREQ < thr_zs_q) |=> flag_q[`OSF_B_ZS]) else $error("zero speed flag missed");
  a_zero_clear: assert property (@(posedge CLK) disable iff (!NRST)
    (OUT_FREQ > thr_zs_q) |=> !flag_q[`OSF_B_ZS]) else $error("zero speed flag stuck");
  a_dev_flag: assert property (@(posedge CLK) disable iff (!NRST)
    ##1 flag_q[`OSF_B_DSE] == $past(dev > thr_dev_q)) else $error("deviation flag wrong");
  a_ofa_flag: assert property (@(posedge CLK) disable iff (!NRST)
    !RUN |=> !flag_q[`OSF_B_OFA] && !flag_q[`OSF_B_SFA]) else $error("arrival while off");
  a_sfa_flag: assert property (@(posedge CLK) disable iff (!NRST)
    (RUN && OUT_FREQ == freq2_q) |=> flag_q[`OSF_B_SFA]) else $error("set arrival missed");
  a_ol2_flag: assert property (@(posedge CLK) disable iff (!NRST)
    (OUT_CURR < thr_ol2_q) |=> !flag_q[`OSF_B_OL2]) else $error("overload flag wrong");
  a_vloss_flag: assert property (@(posedge CLK) disable iff (!NRST)
    (AIN_VOLT < loss_v_q) |=> flag_q[`OSF_B_VLS]) else $error("voltage loss missed");
  a_iloss_flag: assert property (@(posedge CLK) disable iff (!NRST)
    (AIN_CURR < loss_i_q) |=> flag_q[`OSF_B_ILS]) else $error("current loss missed");
  a_pid_set: assert property (@(posedge CLK) disable iff (!NRST)
    (RUN && PID_PV < pid_lo_q && PID_PV <= pid_hi_q) |=> pid_q == PID_ON) else $error("pid not set");
  a_pid_stop: assert property (@(posedge CLK) disable iff (!NRST)
    (run_dly_q && !RUN && pid_q == PID_ON) |=> pid_q == PID_OFF) else $error("pid not cleared");
  a_bool_flag: assert property (@(posedge CLK) disable iff (!NRST)
    ##1 flag_q[`OSF_B_LGC:`OSF_B_LGA] == $past(BOOL_RESULT)) else $error("logic flag wrong");
  a_term_sel: assert property (@(posedge CLK) disable iff (!NRST)
    (sel_q[5:0] == `OSF_CODE_ZS) ##1 (sel_q[5:0] == `OSF_CODE_ZS)
      |-> TERMINAL[0] == $past(flag_q[`OSF_B_ZS])) else $error("terminal select wrong");

endmodule

// *** inc/osf_defines.svh ***
// Constants for the output status flag block: APB offsets, field positions,
// reset values and timing counts. Assumes a 40 MHz system clock.
`ifndef OSF_DEFINES_SVH
`define OSF_DEFINES_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OSF_OFF_SEL0      12'h000
`define OSF_OFF_SEL1      12'h004
`define OSF_OFF_THR_ZS    12'h008
`define OSF_OFF_THR_DEV   12'h00C
`define OSF_OFF_FREQ2     12'h010
`define OSF_OFF_THR_OL2   12'h014
`define OSF_OFF_LOSS_V    12'h018
`define OSF_OFF_LOSS_I    12'h01C
`define OSF_OFF_PID_LO    12'h020
`define OSF_OFF_PID_HI    12'h024
`define OSF_OFF_WDOG      12'h028
`define OSF_OFF_FLAGS     12'h02C
`define OSF_OFF_IRQ_STAT  12'h030
`define OSF_OFF_IRQ_MASK  12'h034
`define OSF_OFF_KICK      12'h038

// ****************************************
// Field positions in the flag vector
// ****************************************
`define OSF_B_ZS    0
`define OSF_B_DSE   1
`define OSF_B_POK   2
`define OSF_B_OFA   3
`define OSF_B_SFA   4
`define OSF_B_OL2   5
`define OSF_B_VLS   6
`define OSF_B_ILS   7
`define OSF_B_PID   8
`define OSF_B_NET   9
`define OSF_B_LGA   10
`define OSF_B_LGB   11
`define OSF_B_LGC   12
`define OSF_B_CAP   13
`define OSF_B_FAN   14
`define OSF_NFLAG   15

// ****************************************
// Option codes, reset values and the watchdog unit count
// ****************************************
`define OSF_CODE_ZS   6'd21
`define OSF_CODE_DSE  6'd22
`define OSF_CODE_POK  6'd23
`define OSF_CODE_OFA  6'd24
`define OSF_CODE_SFA  6'd25
`define OSF_CODE_OL2  6'd26
`define OSF_CODE_VLS  6'd27
`define OSF_CODE_ILS  6'd28
`define OSF_CODE_PID  6'd31
`define OSF_CODE_NET  6'd32
`define OSF_CODE_LGA  6'd33
`define OSF_CODE_LGB  6'd34
`define OSF_CODE_LGC  6'd35
`define OSF_CODE_CAP  6'd39
`define OSF_CODE_FAN  6'd40
`define OSF_RST_SEL   32'h0000_0000
`define OSF_RST_THR   16'h0000
`define OSF_RST_WDOG  32'h0000_0000
`define OSF_WDOG_UNIT 32'h0000_9C40

`endif

// *** inc/osf_pkg.sv ***
// Types shared by the output status flag block.
// Assumes the constants header is included by the user.
package osf_pkg;
  typedef enum logic [1:0] {PID_OFF, PID_ON} osf_pid_t;
endpackage

// *** sim/osf_core_model.sv ***
// Behavioural model of the control core that feeds drive quantities to the flag logic.
// Assumes the bench calls its tasks just after a rising edge of clk.
`timescale 1ns/1ps

module osf_core_model (
  // Clock
  input  wire logic             clk,
  // Quantities toward the flag logic
  output logic                  run,
  output logic [6:0][15:0]      q,
  output logic [2:0]            bool_res,
  output logic [2:0]            pins
);
  // Everything starts idle so the flag logic sees no event out of reset
  initial begin
    run      = 1'b0;
    q        = '0;
    bool_res = 3'b000;
    pins     = 3'b000;
  end

  // Quantities change on the edge so the design samples a settled value
  task automatic set_q(input int i, input logic [15:0] v);
    q[i] <= v;
  endtask

  // Pins are asynchronous in the real part; moving them on the edge is the worst case
  task automatic set_ctl(input logic r, input logic [2:0] b, input logic [2:0] p);
    run      <= r;
    bool_res <= b;
    pins     <= p;
  endtask
endmodule

// *** sim/osf_top_tb.sv ***
// Self-checking bench for the output status flag logic.
// Assumes the constants header on the include path and a zero-wait APB slave.
`timescale 1ns/1ps
`include "osf_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end

module osf_top_tb;
  localparam int FQ = 0, CMD = 1, ACT = 2, CUR = 3, AV = 4, AI = 5, PV = 6;
  logic             CLK = 0, NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0]      PADDR = '0;
  logic [31:0]      PWDATA = '0, PRDATA, r;
  logic             PREADY, PSLVERR, IRQ, RUN, e;
  logic [6:0][15:0] q;
  logic [2:0]       BOOL_RESULT, pins;
  logic [1:0]       TERMINAL;
  int               miscompares = 0, num_checks = 0;

  // ****************************************
  // Design, partner and clock
  // ****************************************
  osf_top i_osf_top (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RUN(RUN), .OUT_FREQ(q[FQ]),
    .SPEED_CMD(q[CMD]), .SPEED_ACT(q[ACT]), .OUT_CURR(q[CUR]), .AIN_VOLT(q[AV]), .AIN_CURR(q[AI]),
    .PID_PV(q[PV]), .BOOL_RESULT(BOOL_RESULT), .POS_DONE(pins[0]), .CAP_EXPIRED(pins[1]),
    .FAN_EXPIRED(pins[2]), .TERMINAL(TERMINAL), .IRQ(IRQ));
  osf_core_model i_core (.clk(CLK), .run(RUN), .q(q), .bool_res(BOOL_RESULT), .pins(pins));
  initial begin
    forever #12.5 CLK = ~CLK;
  end

  // ****************************************
  // Bus and helper tasks
  // ****************************************
  task automatic summarize();
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Request held until pready is seen high at a rising edge; an idle cycle follows
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Answer and read data are taken at the rising edge that sees pready high
    forever begin
      @(posedge CLK);
      if (PREADY === 1'b1) begin
        r = PRDATA;
        e = PSLVERR;
        break;
      end
      if (++n > 20) begin miscompares++; summarize(); end
    end
    PSEL <= 1'b0; PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic flags(input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, `OSF_OFF_FLAGS, '0);
    `CHK(r & m, x)
  endtask
  task automatic cyc(input int n); repeat (n) @(posedge CLK); endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    apb(1'b0, `OSF_OFF_SEL0, '0); `CHK(r, 32'h0000_0000)
    flags(32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b1, 12'h040, 32'hFFFF_FFFF); `CHK(e, 1'b1)
    apb(1'b0, 12'h040, '0); `CHK({e, r}, {1'b1, 32'h0000_0000})
    $display("reset and decode done");
  endtask

  // Zero-speed on terminal 0 also drives the interrupt path
  task automatic t_zero();
    wr(`OSF_OFF_SEL0, 32'h0000_0015); wr(`OSF_OFF_IRQ_MASK, 32'h0000_0001);
    wr(`OSF_OFF_THR_ZS, 32'h0000_0064); cyc(4);
    `CHK({TERMINAL[0], IRQ}, 2'b11)
    i_core.set_q(FQ, 16'h0065); cyc(4);
    `CHK(TERMINAL[0], 1'b0)
    `CHK(IRQ, 1'b1)
    wr(`OSF_OFF_IRQ_STAT, 32'h0000_0001); cyc(3); `CHK(IRQ, 1'b0)
    wr(`OSF_OFF_IRQ_MASK, 32'h0000_0000);
    $display("zero speed done");
  endtask

  task automatic t_dev();
    wr(`OSF_OFF_SEL1, 32'h0000_0016); wr(`OSF_OFF_THR_DEV, 32'h0000_000A);
    i_core.set_q(CMD, 16'h0064); i_core.set_q(ACT, 16'h006F); cyc(4);
    `CHK(TERMINAL[1], 1'b1)
    i_core.set_q(ACT, 16'h006E); cyc(4);
    `CHK(TERMINAL[1], 1'b0)
    $display("deviation done");
  endtask

  // Arrival, overload and loss flags around their thresholds
  task automatic t_levels();
    wr(`OSF_OFF_FREQ2, 32'h0000_01F4); wr(`OSF_OFF_THR_OL2, 32'h0000_012C);
    wr(`OSF_OFF_LOSS_V, 32'h0000_0032); wr(`OSF_OFF_LOSS_I, 32'h0000_003C);
    i_core.set_ctl(1'b1, 3'b000, 3'b000); i_core.set_q(FQ, 16'h01F4); i_core.set_q(CUR, 16'h012D);
    i_core.set_q(AV, 16'h0031); i_core.set_q(AI, 16'h003B); cyc(4);
    flags(32'h0000_00F8, 32'h0000_00F8);
    i_core.set_q(FQ, 16'h01F5); i_core.set_q(CUR, 16'h012B);
    i_core.set_q(AV, 16'h0032); i_core.set_q(AI, 16'h003C); cyc(4);
    flags(32'h0000_00F8, 32'h0000_0008);
    i_core.set_ctl(1'b0, 3'b000, 3'b000); cyc(4);
    flags(32'h0000_0018, 32'h0000_0000);
    $display("levels done");
  endtask

  task automatic t_pid();
    wr(`OSF_OFF_PID_LO, 32'h0000_0064); wr(`OSF_OFF_PID_HI, 32'h0000_00C8);
    i_core.set_ctl(1'b1, 3'b000, 3'b000); i_core.set_q(PV, 16'h0032); cyc(4);
    flags(32'h0000_0100, 32'h0000_0100);
    i_core.set_q(PV, 16'h0096); cyc(4); flags(32'h0000_0100, 32'h0000_0100);
    i_core.set_q(PV, 16'h00C9); cyc(4); flags(32'h0000_0100, 32'h0000_0000);
    i_core.set_q(PV, 16'h0032); cyc(4); flags(32'h0000_0100, 32'h0000_0100);
    i_core.set_ctl(1'b0, 3'b000, 3'b000); cyc(4);
    flags(32'h0000_0100, 32'h0000_0000);
    $display("pid done");
  endtask

  // Synchronised pins need several cycles before they show
  task automatic t_pins();
    i_core.set_ctl(1'b0, 3'b101, 3'b111); cyc(10);
    flags(32'h0000_7C04, 32'h0000_7404);
    i_core.set_ctl(1'b0, 3'b010, 3'b000); cyc(10);
    flags(32'h0000_7C04, 32'h0000_0800);
    $display("pins done");
  endtask

  // One unit of watchdog period is 40000 cycles; kicks keep it quiet
  task automatic t_wdog();
    wr(`OSF_OFF_SEL0, 32'h0000_0020); wr(`OSF_OFF_WDOG, 32'h0000_0001); wr(`OSF_OFF_KICK, '0);
    cyc(30000); flags(32'h0000_0200, 32'h0000_0000);
    wr(`OSF_OFF_KICK, '0); cyc(30000);
    `CHK(TERMINAL[0], 1'b0)
    cyc(12000); `CHK(TERMINAL[0], 1'b1)
    $display("watchdog done");
  endtask

  // ****************************************
  // Main sequence and hang guard
  // ****************************************
  initial begin
    repeat (12) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    t_reset(); t_zero(); t_dev(); t_levels(); t_pid(); t_pins(); t_wdog();
    summarize();
  end
  initial begin
    repeat (95000) @(posedge CLK);
    miscompares++;
    summarize();
  end
endmodule
